// >>> include/usbe_pkg.sv
package usbe_pkg;
   // Register byte offsets on the Avalon-MM slave
   localparam int AVS_AW = 4;
   localparam logic [AVS_AW-1:0] OFS_CSR = 4'h0;
   localparam logic [AVS_AW-1:0] OFS_FIFO = 4'h4;
   localparam logic [AVS_AW-1:0] OFS_CFG = 4'h8;
   // Control and status field positions
   localparam int CSR_TX_COMPLETE = 0;
   localparam int CSR_RX_BANK0 = 1;
   localparam int CSR_SETUP_RCV = 2;
   localparam int CSR_STALL_SENT = 3;
   localparam int CSR_TX_PKT_RDY = 4;
   localparam int CSR_FORCE_STALL = 5;
   localparam int CSR_RX_BANK1 = 6;
   localparam int CSR_RX_COUNT = 16;
   // Configuration field positions
   localparam int CFG_PING_PONG = 0;
   localparam int CFG_INT_EN = 1;
   localparam logic [1:0] CFG_RESET = 2'h0;
   // Bank geometry
   localparam int PTR_W = 6;
   localparam int CNT_W = 7;
   localparam int BANK_AW = 7;
   localparam logic [CNT_W-1:0] EP_BYTES = 7'h40;

   typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} usbe_tok_e;
   typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} usbe_hs_e;

   typedef struct packed {
      logic tokValid;
      usbe_tok_e tokKind;
      logic dataValid;
      logic [7:0] data;
      logic dataEnd;
   } usbe_rx_s;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic last;
      logic empty;
   } usbe_tx_s;

   typedef struct packed {
      logic valid;
      usbe_hs_e code;
   } usbe_hs_s;

   function automatic logic [BANK_AW-1:0] bankAddr(input logic bank, input logic [CNT_W-1:0] ptr);
      bankAddr = {bank, ptr[PTR_W-1:0]};
   endfunction : bankAddr
endpackage : usbe_pkg

// >>> design/usbe_bank_ram.sv
module usbe_bank_ram
   import usbe_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic wrEn, // Write strobe
   input wire logic [BANK_AW-1:0] wrAddr, // Bank and byte index
   input wire logic [7:0] wrData, // Byte to store
   input wire logic [BANK_AW-1:0] rdAddr, // Bank and byte index
   output logic [7:0] rdData // Byte read, one cycle late
);
   logic [7:0] mem [0:(1 << BANK_AW) - 1];

   // No reset: contents are only valid once written
   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule : usbe_bank_ram

// >>> design/usbe_tx_engine.sv
module usbe_tx_engine
   import usbe_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic nrst, // Synchronous reset, active low
   input wire logic start, // Send one packet
   input wire logic bank, // Bank holding the packet
   input wire logic [CNT_W-1:0] len, // Packet length in bytes
   input wire logic linkReady, // Link takes the shown byte
   output logic memRdEn, // Engine owns the read port
   output logic [BANK_AW-1:0] memRdAddr, // Read address
   input wire logic [7:0] memRdData, // Read data
   output usbe_tx_s tx, // Byte stream toward the link
   output logic busy // Packet in progress
);
   typedef enum logic [1:0] {ENG_IDLE, ENG_FETCH, ENG_LOAD, ENG_SHOW} usbe_eng_e;
   usbe_eng_e state_r;
   logic bank_r;
   logic [CNT_W-1:0] len_r;
   logic [CNT_W-1:0] ptr_r;

   assign memRdEn = (state_r == ENG_FETCH);
   assign memRdAddr = bankAddr(bank_r, ptr_r);
   assign busy = (state_r != ENG_IDLE);

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_r <= ENG_IDLE;
         tx <= '0;
         bank_r <= 1'b0;
         len_r <= '0;
         ptr_r <= '0;
      end else begin
         case (state_r)
            ENG_IDLE: begin
               if (start) begin
                  bank_r <= bank;
                  len_r <= len;
                  ptr_r <= '0;
                  if (len == '0) begin
                     // Zero-length packet is a single empty beat
                     tx <= '{valid: 1'b1, data: 8'h00, last: 1'b1, empty: 1'b1};
                     state_r <= ENG_SHOW;
                  end else begin
                     state_r <= ENG_FETCH;
                  end
               end
            end
            ENG_FETCH: state_r <= ENG_LOAD;
            ENG_LOAD: begin
               tx <= '{valid: 1'b1, data: memRdData,
                       last: (ptr_r + 7'h01) == len_r, empty: 1'b0};
               state_r <= ENG_SHOW;
            end
            ENG_SHOW: begin
               if (linkReady) begin
                  tx.valid <= 1'b0;
                  ptr_r <= ptr_r + 7'h01;
                  state_r <= tx.last ? ENG_IDLE : ENG_FETCH;
               end
            end
            default: state_r <= ENG_IDLE;
         endcase
      end
   end
endmodule : usbe_tx_engine

// >>> design/usbe_endpoint.sv
module usbe_endpoint
   import usbe_pkg::*;
(
   input wire logic clk_sys, // System clock, 100 MHz
   input wire logic nrst, // Synchronous reset, active low
   input wire logic [AVS_AW-1:0] avsAddress, // Byte address
   input wire logic avsRead, // Read request
   input wire logic avsWrite, // Write request
   input wire logic [31:0] avsWriteData, // Write data
   input wire logic [3:0] avsByteEnable, // Byte lanes
   output logic [31:0] avsReadData, // Read data
   output logic avsWaitRequest, // Stall the master
   input wire usbe_rx_s usbRx, // Tokens and received bytes
   input wire logic usbHostAck, // Host ACK after IN data
   input wire logic usbTxReady, // Link takes the shown byte
   output usbe_tx_s usbTx, // IN data stream
   output usbe_hs_s usbHs, // Handshake to return
   output logic irq // Endpoint interrupt, level
);
   logic cfgPingPong_r, cfgIntEn_r;
   logic tx_complete_r, setupRcv_r, stall_sent_b_r, force_stall_a_r;
   logic [1:0] rxFull_r, txReady_r;
   logic [CNT_W-1:0] txLen_r [0:1];
   logic [CNT_W-1:0] rxCnt_r [0:1];
   logic fillBank_r, sendBank_r, rdBank_r, rxNextBank_r;
   logic [CNT_W-1:0] fwPtr_r;
   logic rxActive_r, rxAccept_r, setup_received_r, rxStall_r, rxBank_r;
   logic [CNT_W-1:0] rxPtr_r;
   logic inFlight_r, inBank_r, rdStage_r;
   logic [7:0] ramRdData;
   logic engRdEn, engBusy, engStart;
   logic [BANK_AW-1:0] engRdAddr;

   logic csrWr, cfgWr, fifoWr, fifoRd, fifoWrOk, fifoRdOk;
   logic usbWe, fwRxBank, tokIn, tokOut, tokSetup, outFree, outBank;
   logic inGo, inAcked, rxDone, stallHs;
   logic [1:0] rxSet, rxClr;
   logic pending;

   assign csrWr = avsWrite && (avsAddress == OFS_CSR) && avsByteEnable[0];
   assign cfgWr = avsWrite && (avsAddress == OFS_CFG) && avsByteEnable[0];
   assign fifoWr = avsWrite && (avsAddress == OFS_FIFO) && avsByteEnable[0];
   assign fifoRd = avsRead && (avsAddress == OFS_FIFO);
   assign usbWe = rxActive_r && rxAccept_r && usbRx.dataValid && (rxPtr_r < EP_BYTES);
   // The USB side cannot be held off, so firmware waits on port clashes
   assign fifoWrOk = fifoWr && !usbWe;
   assign fifoRdOk = fifoRd && rdStage_r;
   assign avsWaitRequest = (fifoWr && usbWe) || (fifoRd && !rdStage_r);

   // Firmware reads the setup bank first, else the bank its order tracks
   assign fwRxBank = setupRcv_r ? 1'b0 : (cfgPingPong_r ? rdBank_r : 1'b0);

   always_comb begin
      avsReadData = 32'h0000_0000;
      if (avsRead) begin
         case (avsAddress)
            OFS_CSR: begin
               avsReadData[CSR_TX_COMPLETE] = tx_complete_r;
               avsReadData[CSR_RX_BANK0] = rxFull_r[0];
               avsReadData[CSR_SETUP_RCV] = setupRcv_r;
               avsReadData[CSR_STALL_SENT] = stall_sent_b_r;
               avsReadData[CSR_TX_PKT_RDY] = |txReady_r;
               avsReadData[CSR_FORCE_STALL] = force_stall_a_r;
               avsReadData[CSR_RX_BANK1] = rxFull_r[1];
               // count of the bank firmware reads
               avsReadData[CSR_RX_COUNT +: CNT_W] = rxCnt_r[fwRxBank];
            end
            OFS_FIFO: avsReadData[7:0] = ramRdData;
            OFS_CFG: begin
               avsReadData[CFG_PING_PONG] = cfgPingPong_r;
               avsReadData[CFG_INT_EN] = cfgIntEn_r;
            end
            default: avsReadData = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         {cfgIntEn_r, cfgPingPong_r} <= CFG_RESET;
      end else if (cfgWr) begin
         cfgPingPong_r <= avsWriteData[CFG_PING_PONG];
         cfgIntEn_r <= avsWriteData[CFG_INT_EN];
      end
   end

   // Second cycle of a FIFO read returns the registered RAM byte
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rdStage_r <= 1'b0;
      end else begin
         rdStage_r <= fifoRd && !rdStage_r && !engRdEn;
      end
   end

   usbe_bank_ram u_ram (
      .clk_sys(clk_sys),
      .wrEn(usbWe || fifoWrOk),
      .wrAddr(usbWe ? bankAddr(rxBank_r, rxPtr_r) : bankAddr(fillBank_r, fwPtr_r)),
      .wrData(usbWe ? usbRx.data : avsWriteData[7:0]),
      .rdAddr(engRdEn ? engRdAddr : bankAddr(fwRxBank, fwPtr_r)),
      .rdData(ramRdData)
   );

   // Token decode
   assign tokIn = usbRx.tokValid && (usbRx.tokKind == TOK_IN);
   assign tokOut = usbRx.tokValid && (usbRx.tokKind == TOK_OUT);
   assign tokSetup = usbRx.tokValid && (usbRx.tokKind == TOK_SETUP);
   // single bank free only when firmware has released it
   // ping-pong takes the next bank in turn
   assign outBank = cfgPingPong_r ? rxNextBank_r : 1'b0;
   assign outFree = !rxFull_r[outBank] && !setupRcv_r;
   // data goes only from a bank marked ready
   assign inGo = tokIn && !force_stall_a_r && txReady_r[sendBank_r] && !engBusy;
   assign engStart = inGo;
   assign inAcked = usbHostAck && inFlight_r;
   assign rxDone = rxActive_r && usbRx.dataEnd;
   // stall answers IN and OUT, never a setup
   assign stallHs = (tokIn && force_stall_a_r) || (rxDone && rxStall_r);

   usbe_tx_engine u_tx (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .start(engStart),
      .bank(sendBank_r),
      .len(txLen_r[sendBank_r]),
      .linkReady(usbTxReady),
      .memRdEn(engRdEn),
      .memRdAddr(engRdAddr),
      .memRdData(ramRdData),
      .tx(usbTx),
      .busy(engBusy)
   );

   // Receive side of one OUT or SETUP transaction
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rxActive_r <= 1'b0;
         rxAccept_r <= 1'b0;
         setup_received_r <= 1'b0;
         rxStall_r <= 1'b0;
         rxBank_r <= 1'b0;
         rxPtr_r <= '0;
      end else if (tokOut || tokSetup) begin
         rxActive_r <= 1'b1;
         setup_received_r <= tokSetup;
         // a setup always lands in bank zero
         rxStall_r <= tokOut && force_stall_a_r;
         rxAccept_r <= tokSetup || (outFree && !force_stall_a_r);
         rxBank_r <= tokSetup ? 1'b0 : outBank;
         rxPtr_r <= '0;
      end else begin
         if (usbWe) begin
            rxPtr_r <= rxPtr_r + 7'h01;
         end
         if (rxDone) begin
            rxActive_r <= 1'b0;
         end
      end
   end

   // Handshake answer, one cycle pulse
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         usbHs <= '{valid: 1'b0, code: HS_ACK};
      end else if (stallHs) begin
         usbHs <= '{valid: 1'b1, code: HS_STALL};
      end else if (tokIn && !inGo) begin
         usbHs <= '{valid: 1'b1, code: HS_NAK};
      end else if (rxDone) begin
         // ACK stored data, NAK while firmware owns the bank
         usbHs <= '{valid: 1'b1, code: rxAccept_r ? HS_ACK : HS_NAK};
      end else begin
         usbHs <= '{valid: 1'b0, code: HS_ACK};
      end
   end

   // flags set on a stored OUT payload
   always_comb begin
      rxSet = 2'b00;
      rxClr = 2'b00;
      if (rxDone && rxAccept_r && !setup_received_r) begin
         rxSet[rxBank_r] = 1'b1;
      end
      if (csrWr) begin
         rxClr[0] = !avsWriteData[CSR_RX_BANK0];
         rxClr[1] = !avsWriteData[CSR_RX_BANK1];
      end
   end

   // Sticky flags: writing zero clears, a hardware set in the same cycle wins
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rxFull_r <= 2'b00;
         setupRcv_r <= 1'b0;
         stall_sent_b_r <= 1'b0;
         tx_complete_r <= 1'b0;
         force_stall_a_r <= 1'b0;
      end else begin
         rxFull_r <= rxSet | (rxFull_r & ~rxClr);
         // setup flag held until firmware clears it
         setupRcv_r <= (rxDone && rxAccept_r && setup_received_r) ||
                       (setupRcv_r && !(csrWr && !avsWriteData[CSR_SETUP_RCV]));
         stall_sent_b_r <= stallHs ||
                        (stall_sent_b_r && !(csrWr && !avsWriteData[CSR_STALL_SENT]));
         // host ACK of IN data sets transmit complete
         tx_complete_r <= inAcked ||
                     (tx_complete_r && !(csrWr && !avsWriteData[CSR_TX_COMPLETE]));
         if (csrWr) begin
            force_stall_a_r <= avsWriteData[CSR_FORCE_STALL];
         end
      end
   end

   // byte count and bank order of received payloads
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rxCnt_r[0] <= '0;
         rxCnt_r[1] <= '0;
         rxNextBank_r <= 1'b0;
         rdBank_r <= 1'b0;
      end else begin
         if (rxDone && rxAccept_r) begin
            rxCnt_r[rxBank_r] <= rxPtr_r;
            // next OUT goes to the other bank
            if (cfgPingPong_r && !setup_received_r) begin
               rxNextBank_r <= !rxBank_r;
            end
         end
         // in ping-pong, release of the read bank moves firmware reads to the other
         if (cfgPingPong_r && rxClr[rdBank_r] && rxFull_r[rdBank_r]) begin
            rdBank_r <= !rdBank_r;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         txReady_r <= 2'b00;
         txLen_r[0] <= '0;
         txLen_r[1] <= '0;
         fillBank_r <= 1'b0;
         sendBank_r <= 1'b0;
         inFlight_r <= 1'b0;
         inBank_r <= 1'b0;
      end else begin
         // ready flag hands the filled bank to the device
         if (csrWr && avsWriteData[CSR_TX_PKT_RDY] && !txReady_r[fillBank_r]) begin
            txReady_r[fillBank_r] <= 1'b1;
            txLen_r[fillBank_r] <= fwPtr_r;
            if (cfgPingPong_r) begin
               fillBank_r <= !fillBank_r;
            end
         end
         if (usbRx.tokValid) begin
            // A new token without an ACK means the host will retry
            inFlight_r <= inGo;
            inBank_r <= sendBank_r;
         end else if (inAcked) begin
            inFlight_r <= 1'b0;
            txReady_r[inBank_r] <= 1'b0;
            if (cfgPingPong_r) begin
               sendBank_r <= !inBank_r;
            end
         end
      end
   end

   // Firmware FIFO pointer restarts whenever firmware hands a bank to the device
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         fwPtr_r <= '0;
      end else if (csrWr && (avsWriteData[CSR_TX_PKT_RDY] || |(rxClr & rxFull_r) ||
                             (setupRcv_r && !avsWriteData[CSR_SETUP_RCV]))) begin
         fwPtr_r <= '0;
      end else if ((fifoWrOk || fifoRdOk) && (fwPtr_r < EP_BYTES)) begin
         fwPtr_r <= fwPtr_r + 7'h01;
      end
   end

   // level interrupt from all pending flags
   assign pending = tx_complete_r || (|rxFull_r) || setupRcv_r || stall_sent_b_r;
   assign irq = cfgIntEn_r && pending;

   sequence sqOutBusy;
      tokOut && !force_stall_a_r && !outFree;
   endsequence

   sequence sqSetupStart;
      tokSetup;
   endsequence

   // IN with no ready bank is refused
   chk_in_nak_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
      tokIn && !force_stall_a_r && !txReady_r[sendBank_r] |=> usbHs.valid && usbHs.code == HS_NAK)
      else $error("IN without ready bank not NAKed");
   chk_stall_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst)
      tokIn && force_stall_a_r |=> usbHs.code == HS_STALL && usbHs.valid && stall_sent_b_r)
      else $error("Forced stall not answered or not flagged");
   chk_tx_complete_on_ack: assert property (@(posedge clk_sys) disable iff (!nrst)
      inAcked |=> tx_complete_r && !txReady_r[$past(inBank_r)])
      else $error("Host ACK did not complete the bank");
   // busy single bank OUT is refused at the token
   chk_out_nak_busy: assert property (@(posedge clk_sys) disable iff (!nrst)
      sqOutBusy |=> rxActive_r && !rxAccept_r)
      else $error("OUT into owned bank was accepted");
   // refused OUT is NAKed at packet end
   chk_out_nak_end: assert property (@(posedge clk_sys) disable iff (!nrst)
      rxDone && !rxAccept_r && !rxStall_r && !tokIn |=> usbHs.valid && usbHs.code == HS_NAK)
      else $error("Refused OUT not NAKed");
   // setup always accepted into bank zero
   chk_setup_taken: assert property (@(posedge clk_sys) disable iff (!nrst)
      sqSetupStart |=> rxActive_r && rxAccept_r && setup_received_r && !rxBank_r)
      else $error("Setup not accepted into bank zero");
   chk_setup_acked: assert property (@(posedge clk_sys) disable iff (!nrst)
      rxDone && setup_received_r |=> usbHs.code == HS_ACK && usbHs.valid && setupRcv_r)
      else $error("Setup not acknowledged");
   // stored OUT payload raises its bank flag
   chk_rx_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst)
      rxDone && rxAccept_r && !setup_received_r |=> rxFull_r[$past(rxBank_r)])
      else $error("Receive bank flag not set");
   chk_rx_count: assert property (@(posedge clk_sys) disable iff (!nrst)
      rxDone && rxAccept_r |=> rxCnt_r[$past(rxBank_r)] == $past(rxPtr_r))
      else $error("Receive byte count wrong");
   // ping-pong send bank alternates on ACK
   chk_bank_alternate: assert property (@(posedge clk_sys) disable iff (!nrst)
      inAcked && cfgPingPong_r |=> sendBank_r != $past(sendBank_r))
      else $error("Send bank did not alternate");
   // interrupt holds while flags stay untouched
   chk_irq_level: assert property (@(posedge clk_sys) disable iff (!nrst)
      irq && !csrWr && !cfgWr |=> irq)
      else $error("Interrupt dropped without a clear");
endmodule : usbe_endpoint

// >>> test/usbe_host_model.sv
module usbe_host_model
   import usbe_pkg::*;
(
   input wire logic clk_sys, // System clock
   output usbe_rx_s usbRx, // Tokens and OUT bytes
   output logic usbHostAck, // ACK after IN data
   output logic usbTxReady, // Takes the shown byte
   input wire usbe_tx_s usbTx, // IN data from device
   input wire usbe_hs_s usbHs // Handshake from device
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] lastHs;
   logic [7:0] inBytes[$];
   int slow = 0;
   initial begin
      usbRx = '0;
      usbHostAck = 1'b0;
      usbTxReady = 1'b0;
   end
   task automatic token(input usbe_tok_e kind);
      @(posedge clk_sys);
      usbRx.tokValid <= 1'b1;
      usbRx.tokKind <= kind;
      @(posedge clk_sys);
      usbRx.tokValid <= 1'b0;
   endtask : token
   // 2'h3 marks no answer within the bound
   task automatic waitHs();
      lastHs = 2'h3;
      for (int n = 0; n < 50 && lastHs == 2'h3; n++) begin
         @(posedge clk_sys);
         if (usbHs.valid === 1'b1)
            lastHs = usbHs.code;
      end
   endtask : waitHs
   task automatic outPkt(input usbe_tok_e kind, input int n, input logic [7:0] base);
      token(kind);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         usbRx.dataValid <= 1'b1;
         usbRx.data <= base + 8'(i);
      end
      @(posedge clk_sys);
      usbRx.dataValid <= 1'b0;
      // Idle data flips so a stale byte is never mistaken for a new one
      usbRx.data <= ~usbRx.data;
      usbRx.dataEnd <= 1'b1;
      @(posedge clk_sys);
      usbRx.dataEnd <= 1'b0;
      waitHs();
   endtask : outPkt
   // Host ACK only after the last beat, before any next token
   task automatic inPkt();
      inBytes.delete();
      token(TOK_IN);
      lastHs = 2'h3;
      for (int n = 0; n < 400 && lastHs == 2'h3; n++) begin
         @(posedge clk_sys);
         if (usbHs.valid === 1'b1)
            lastHs = usbHs.code;
         else if (usbTx.valid === 1'b1) begin
            repeat (slow) @(posedge clk_sys);
            usbTxReady <= 1'b1;
            @(posedge clk_sys);
            usbTxReady <= 1'b0;
            if (usbTx.empty !== 1'b1)
               inBytes.push_back(usbTx.data);
            if (usbTx.last === 1'b1) begin
               @(posedge clk_sys);
               usbHostAck <= 1'b1;
               lastHs = HS_ACK;
               @(posedge clk_sys);
               usbHostAck <= 1'b0;
            end
         end
      end
   endtask : inPkt
endmodule : usbe_host_model

// >>> test/test_usbe_endpoint.sv
module test_usbe_endpoint;
   import usbe_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, nrst, avsRead, avsWrite, avsWaitRequest, usbHostAck, usbTxReady, irq;
   logic [AVS_AW-1:0] avsAddress;
   logic [31:0] avsWriteData, avsReadData, csrQ;
   logic [3:0] avsByteEnable;
   usbe_rx_s usbRx;
   usbe_tx_s usbTx;
   usbe_hs_s usbHs;
   int miscompares = 0;
   int testsRun = 0;
   usbe_endpoint u_usbe_endpoint (.clk_sys(clk_sys), .nrst(nrst), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
      .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest), .usbRx(usbRx), .usbHostAck(usbHostAck),
      .usbTxReady(usbTxReady), .usbTx(usbTx), .usbHs(usbHs), .irq(irq));
   usbe_host_model u_usbe_host_model (.clk_sys(clk_sys), .usbRx(usbRx),
      .usbHostAck(usbHostAck), .usbTxReady(usbTxReady), .usbTx(usbTx), .usbHs(usbHs));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic testDone();
      $display("comparisons %0d mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : testDone
   initial begin
      #400000;
      miscompares++;
      testDone();
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic rst();
      nrst <= 1'b0;
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
   endtask : rst
   // Request held until waitrequest is seen low at a rising edge
   task automatic busOp(input logic wr, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
      @(posedge clk_sys);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= ~wr;
      avsWriteData <= d;
      // Only the watchdog ends a wait that never sees waitrequest low
      do begin
         @(posedge clk_sys);
      end while (avsWaitRequest !== 1'b0);
      q = avsReadData;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask : busOp
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      busOp(1'b1, a, d, q);
   endtask : wr
   task automatic csr(input logic [6:0] flags, input logic expIrq);
      busOp(1'b0, OFS_CSR, 32'h0, csrQ);
      chk(csrQ[6:0], flags);
      chk(irq, expIrq);
   endtask : csr
   task automatic fill(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++)
         wr(OFS_FIFO, {24'h0, base + 8'(i)});
   endtask : fill
   task automatic drain(input int n, input logic [7:0] base);
      logic [31:0] q;
      for (int i = 0; i < n; i++) begin
         busOp(1'b0, OFS_FIFO, 32'h0, q);
         chk(q[7:0], base + 8'(i));
      end
   endtask : drain
   task automatic expectIn(input logic [1:0] hs, input int n, input logic [15:0] b);
      u_usbe_host_model.inPkt();
      chk(u_usbe_host_model.lastHs, hs);
      chk(u_usbe_host_model.inBytes.size(), n);
      foreach (u_usbe_host_model.inBytes[i])
         chk(u_usbe_host_model.inBytes[i], b[8*i+:8]);
   endtask : expectIn
   task automatic out(usbe_tok_e k, int n, logic [7:0] base, logic [1:0] hs);
      u_usbe_host_model.outPkt(k, n, base);
      chk(u_usbe_host_model.lastHs, hs);
   endtask : out
   task automatic testRegs();
      logic [31:0] q;
      csr(7'h0, 1'b0);
      wr(4'hc, 32'hffff_ffff);
      busOp(1'b0, 4'hc, 32'h0, q);
      chk(q, 32'h0);
      $display("register test done");
   endtask : testRegs
   task automatic testSingleIn();
      wr(OFS_CFG, 32'h2);
      expectIn(HS_NAK, 0, 16'h0);
      fill(2, 8'h10);
      wr(OFS_CSR, 32'h10);
      csr(7'h10, 1'b0);
      expectIn(HS_ACK, 2, 16'h1110);
      csr(7'h01, 1'b1);
      wr(OFS_CSR, 32'h11);
      wr(OFS_CSR, 32'h00);
      expectIn(HS_ACK, 0, 16'h0);
      csr(7'h01, 1'b1);
      wr(OFS_CSR, 32'h00);
      csr(7'h00, 1'b0);
      $display("single IN test done");
   endtask : testSingleIn
   task automatic testPingIn();
      rst();
      u_usbe_host_model.slow = 3;
      wr(OFS_CFG, 32'h3);
      fill(1, 8'h20);
      wr(OFS_CSR, 32'h10);
      fill(1, 8'h21);
      expectIn(HS_ACK, 1, 16'h20);
      csr(7'h01, 1'b1);
      wr(OFS_CSR, 32'h11);
      wr(OFS_CSR, 32'h00);
      expectIn(HS_ACK, 1, 16'h21);
      wr(OFS_CSR, 32'h00);
      expectIn(HS_NAK, 0, 16'h0);
      u_usbe_host_model.slow = 0;
      $display("ping-pong IN test done");
   endtask : testPingIn
   task automatic testSingleOut();
      rst();
      wr(OFS_CFG, 32'h2);
      out(TOK_OUT, 3, 8'h30, HS_ACK);
      csr(7'h02, 1'b1);
      chk(csrQ[22:16], 7'd3);
      out(TOK_OUT, 1, 8'h40, HS_NAK);
      drain(3, 8'h30);
      wr(OFS_CSR, 32'h0);
      csr(7'h00, 1'b0);
      out(TOK_OUT, 1, 8'h41, HS_ACK);
      $display("single OUT test done");
   endtask : testSingleOut
   task automatic testPingOut();
      rst();
      wr(OFS_CFG, 32'h3);
      out(TOK_OUT, 3, 8'h50, HS_ACK);
      out(TOK_OUT, 2, 8'h60, HS_ACK);
      csr(7'h42, 1'b1);
      chk(csrQ[22:16], 7'd3);
      out(TOK_OUT, 1, 8'h70, HS_NAK);
      drain(3, 8'h50);
      wr(OFS_CSR, 32'h40);
      csr(7'h40, 1'b1);
      chk(csrQ[22:16], 7'd2);
      drain(2, 8'h60);
      wr(OFS_CSR, 32'h0);
      csr(7'h00, 1'b0);
      out(TOK_OUT, 1, 8'h71, HS_ACK);
      csr(7'h02, 1'b1);
      $display("ping-pong OUT test done");
   endtask : testPingOut
   // Functional stall on a single-bank endpoint, then a setup is still accepted while the stall stays set
   task automatic testStall();
      rst();
      wr(OFS_CFG, 32'h2);
      wr(OFS_CSR, 32'h20);
      expectIn(HS_STALL, 0, 16'h0);
      csr(7'h28, 1'b1);
      out(TOK_OUT, 2, 8'h80, HS_STALL);
      out(TOK_SETUP, 2, 8'h90, HS_ACK);
      csr(7'h2c, 1'b1);
      wr(OFS_CSR, 32'h24);
      csr(7'h24, 1'b1);
      drain(2, 8'h90);
      wr(OFS_CFG, 32'h0);
      csr(7'h24, 1'b0);
      wr(OFS_CSR, 32'h0);
      csr(7'h00, 1'b0);
      $display("stall test done");
   endtask : testStall
   initial begin
      nrst = 1'b0;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsAddress = '0;
      avsWriteData = '0;
      avsByteEnable = 4'hf;
      rst();
      testRegs();
      testSingleIn();
      testPingIn();
      testSingleOut();
      testPingOut();
      testStall();
      testDone();
   end
endmodule : test_usbe_endpoint
